// File: verification/clock_source_model.sv
// Reference clock pins and converter power flags seen by the clock tree
`timescale 1ns/1ps
module clock_source_model #(
  parameter int HALF_M = 12,
  parameter int HALF_B = 16,
  parameter int HALF_G = 20,
  parameter int DOWN   = 50
) (
  input  wire logic clk_i,
  input  wire logic play_on_i,
  input  wire logic rec_on_i,
  output logic      master_o,
  output logic      bit_o,
  output logic      gp_o,
  output logic      play_left_o,
  output logic      play_right_o,
  output logic      rec_o
);
  int t  = 0;
  int dp = 0;
  int dr = 0;
  initial {master_o, bit_o, gp_o, play_left_o, play_right_o, rec_o} = '0;
  // Reference clocks run free; flags lag power-down by a shutdown sequence
  always @(posedge clk_i)
  begin
    t            <= t + 1;
    master_o     <= ((t / HALF_M) % 2) == 1;
    bit_o        <= ((t / HALF_B) % 2) == 1;
    gp_o         <= ((t / HALF_G) % 2) == 1;
    dp           <= play_on_i ? DOWN : (dp > 0 ? dp - 1 : 0);
    dr           <= rec_on_i ? DOWN : (dr > 0 ? dr - 1 : 0);
    play_left_o  <= play_on_i || dp > 0;
    play_right_o <= play_on_i || dp > 1;
    rec_o        <= rec_on_i || dr > 0;
  end
endmodule : clock_source_model

// File: verification/codec_clock_tree_tb.sv
// Self-checking bench for the codec clock tree
`timescale 1ns/1ps
module codec_clock_tree_tb;
  import clock_tree_pkg::*;
  localparam int W = 2400;
  localparam int R0 = W / 12;
  logic       clk_sys_i = 1'b0;
  logic       resetn_i  = 1'b0;
  logic [5:0] adr       = 6'h00;
  logic       rd        = 1'b0;
  logic       wr        = 1'b0;
  logic [7:0] wd        = 8'h00;
  logic       play_on   = 1'b0;
  logic       rec_on    = 1'b0;
  logic [31:0] rdata;
  logic       wait_rq, m_src, b_src, g_src, pl, pr, rp;
  logic       root, pblk, pmod, psmp, rblk, rmod, rsmp;
  logic       bclk, bclk_oe, gp1, gp1_oe, sdo, sdo_oe, locked;
  wire        bit_pin = bclk_oe ? bclk : b_src;
  wire        gp_pin  = gp1_oe ? gp1 : g_src;
  int         err_total = 0;
  int         compares  = 0;
  int         seed      = 32'he2c2;
  int         n;
  int         cnt[9], base[9], d[9];
  int         bx[4]     = '{50, 16, 25, 25};
  int         gx[8]     = '{50, 6, 30, 0, 25, 8, 12, 12};
  logic [8:0] obs, obs_q;
  logic [7:0] q, v;
  logic [5:0] rw[17] = '{6'h04, 6'h05, 6'h06, 6'h07, 6'h08, 6'h0b,
    6'h0c, 6'h0d, 6'h0e, 6'h12, 6'h13, 6'h14, 6'h19, 6'h1a, 6'h1b,
    6'h1d, 6'h1e};

  codec_clock_tree #(.LOCK_WAIT(20)) codec_clock_tree_inst (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .address_i(adr),
    .read_i(rd), .write_i(wr), .byteenable_i(4'hf),
    .writedata_i({24'h0, wd}), .readdata_o(rdata),
    .waitrequest_o(wait_rq), .master_clock_i(m_src),
    .bit_clock_i(bit_pin), .general_pin_one_i(gp_pin),
    .play_left_powered_i(pl), .play_right_powered_i(pr),
    .rec_powered_i(rp), .root_codec_clock_o(root),
    .playback_block_clock_o(pblk), .playback_modulator_clock_o(pmod),
    .playback_sample_clock_o(psmp), .record_block_clock_o(rblk),
    .record_modulator_clock_o(rmod), .record_sample_clock_o(rsmp),
    .bit_clock_o(bclk), .bit_clock_oe_o(bclk_oe),
    .general_pin_one_o(gp1), .general_pin_one_oe_o(gp1_oe),
    .serial_data_gp_o(sdo), .serial_data_gp_oe_o(sdo_oe),
    .synth_locked_o(locked));

  clock_source_model clock_source_model_inst (
    .clk_i(clk_sys_i), .play_on_i(play_on), .rec_on_i(rec_on),
    .master_o(m_src), .bit_o(b_src), .gp_o(g_src),
    .play_left_o(pl), .play_right_o(pr), .rec_o(rp));

  initial forever #2.5 clk_sys_i = ~clk_sys_i;

  // Edge counters on the clock outputs, sampled on the system clock
  // Only one of the two general clock outputs toggles at a time
  assign obs = {rsmp, rblk, pblk, gp1 ^ sdo, bclk, rmod, psmp, pmod, root};
  always @(posedge clk_sys_i)
  begin
    obs_q <= obs;
    for (int i = 0; i < 9; i++)
      if (obs[i] !== obs_q[i]) cnt[i] <= cnt[i] + 1;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task end_sim();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task near(input int got, input int exp, input int tol);
    chk((got >= exp - tol && got <= exp + tol) ? exp : got, exp);
  endtask : near

  task bus(input logic w, input logic [5:0] a, input logic [7:0] dv);
    int k;
    @(posedge clk_sys_i);
    adr <= a;
    wr  <= w;
    rd  <= !w;
    wd  <= dv;
    k = 0;
    do
    begin
      @(posedge clk_sys_i);
      k++;
    end
    while (wait_rq !== 1'b0 && k < 20);
    if (k >= 20)
    begin
      err_total++;
      end_sim();
    end
    q = rdata[7:0];
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus

  task wreg(input logic [5:0] a, input logic [7:0] dv);
    bus(1'b1, a, dv);
  endtask : wreg

  task rchk(input logic [5:0] a, input logic [7:0] e,
            input logic [7:0] m = 8'hff);
    bus(1'b0, a, 8'h00);
    chk({rdata[31:8], q & m}, {24'h0, e & m});
  endtask : rchk

  function automatic logic [7:0] fmask(input logic [5:0] a);
    case (a)
      REG_ROOT_SEL, REG_PLAY_OSR_U, REG_SIF_CLK: return 8'h03;
      REG_PLL_J, REG_FRAC_UP: return 8'h3f;
      REG_GP_SEL: return 8'h07;
      REG_GP_DIV, REG_BCLK_DIV: return 8'h7f;
      REG_SIF_CTRL: return 8'h08;
      default: return 8'hff;
    endcase
  endfunction : fmask

  task do_reset();
    @(posedge clk_sys_i);
    resetn_i <= 1'b0;
    repeat (5) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
  endtask : do_reset

  task meas();
    base = cnt;
    repeat (W) @(posedge clk_sys_i);
    foreach (d[i]) d[i] = cnt[i] - base[i];
  endtask : meas

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    do_reset();
    rchk(REG_PLL_CTRL, RST_PLL_CTRL);
    rchk(REG_PLL_J, RST_PLL_J);
    rchk(REG_FRAC_LO, RST_ZERO);
    rchk(REG_PLAY_N, RST_DIV);
    wreg(6'h02, 8'h5a);
    rchk(6'h02, 8'h00);
    wreg(REG_PLAY_STAT, 8'hff);
    rchk(REG_PLAY_STAT, 8'h00);
    play_on <= 1'b1;
    rec_on  <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    rchk(REG_PLAY_STAT, 8'h88);
    rchk(REG_REC_STAT, 8'h40);
    play_on <= 1'b0;
    rec_on  <= 1'b0;
    repeat (60) @(posedge clk_sys_i);
    for (int i = 0; i < 34; i++)
    begin
      v = 8'($random(seed));
      wreg(rw[i % 17], v);
      rchk(rw[i % 17], v, fmask(rw[i % 17]));
    end
    do_reset();
    for (int s = 0; s < 3; s++)
    begin
      wreg(REG_ROOT_SEL, s[7:0]);
      meas();
      near(d[0], W / (12 + 4 * s), 3);
    end
    wreg(REG_ROOT_SEL, 8'h00);
    wreg(REG_PLAY_N, 8'h02);
    wreg(REG_PLAY_M, 8'h03);
    wreg(REG_PLAY_OSR_L, 8'h04);
    wreg(REG_PLAY_N, 8'h82);
    wreg(REG_PLAY_M, 8'h83);
    play_on <= 1'b1;
    meas();
    near(d[1], R0 / 6, 2);
    near(d[2], R0 / 24, 2);
    near(d[3], R0 / 6, 2);
    near(d[6], R0 / 2, 2);
    wreg(REG_REC_N, 8'h04);
    wreg(REG_REC_M, 8'h01);
    wreg(REG_REC_N, 8'h84);
    // Ratio written while the record second divider is still off
    wreg(REG_REC_OSR, 8'h05);
    wreg(REG_REC_M, 8'h81);
    rec_on <= 1'b1;
    meas();
    near(d[3], R0 / 4, 2);
    near(d[7], R0 / 4, 2);
    near(d[8], R0 / 20, 2);
    wreg(REG_BCLK_DIV, 8'h02);
    wreg(REG_SIF_CTRL, 8'h08);
    repeat (2) @(posedge clk_sys_i);
    chk(bclk_oe, 1'b1);
    for (int s = 0; s < 4; s++)
    begin
      wreg(REG_SIF_CLK, s[7:0]);
      meas();
      near(d[4], bx[s], 2);
    end
    wreg(REG_GP_DIV, 8'h04);
    wreg(REG_GP_ROUTE, 8'h01);
    repeat (2) @(posedge clk_sys_i);
    chk(gp1_oe, 1'b1);
    for (int s = 0; s < 8; s++)
    begin
      // A driven general pin would only see its own output as source
      wreg(REG_GP_ROUTE, (s == 2) ? 8'h02 : 8'h01);
      wreg(REG_GP_SEL, s[7:0]);
      meas();
      near(d[5], gx[s], 2);
    end
    wreg(REG_GP_ROUTE, 8'h02);
    repeat (2) @(posedge clk_sys_i);
    chk(sdo_oe, 1'b1);
    wreg(REG_REC_M, 8'h01);
    wreg(REG_REC_N, 8'h04);
    meas();
    near(d[3], R0 / 4, 2);
    rec_on <= 1'b0;
    repeat (80) @(posedge clk_sys_i);
    meas();
    near(d[3], R0 / 6, 2);
    wreg(REG_PLAY_M, 8'h03);
    wreg(REG_PLAY_N, 8'h02);
    meas();
    near(d[1], R0 / 6, 2);
    play_on <= 1'b0;
    repeat (80) @(posedge clk_sys_i);
    meas();
    near(d[1], 0, 0);
    wreg(REG_GP_ROUTE, 8'h00);
    wreg(REG_PLL_CTRL, 8'h91);
    n = 0;
    while (locked !== 1'b1 && n < 200)
    begin
      @(posedge clk_sys_i);
      n++;
    end
    near(n, 20, 6);
    wreg(REG_ROOT_SEL, 8'h03);
    meas();
    near(d[0], R0 * 4, 8);
    wreg(REG_FRAC_UP, 8'h13);
    meas();
    near(d[0], R0 * 4, 8);
    wreg(REG_FRAC_LO, 8'h88);
    meas();
    near(d[0], R0 * 9 / 2, 8);
    wreg(REG_PLL_CTRL, 8'ha3);
    repeat (60) @(posedge clk_sys_i);
    meas();
    near(d[0], R0 * 27 / 4, 10);
    wreg(REG_PLL_CTRL, 8'h23);
    repeat (10) @(posedge clk_sys_i);
    chk(locked, 1'b0);
    meas();
    near(d[0], 0, 0);
    end_sim();
  end
endmodule : codec_clock_tree_tb

// File: verilog/clock_tree_pkg.sv
// Constants and types shared by the codec clock tree
package clock_tree_pkg;

  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [5:0] REG_ROOT_SEL   = 6'h04;
  localparam logic [5:0] REG_PLL_CTRL   = 6'h05;
  localparam logic [5:0] REG_PLL_J      = 6'h06;
  localparam logic [5:0] REG_FRAC_UP    = 6'h07;
  localparam logic [5:0] REG_FRAC_LO    = 6'h08;
  localparam logic [5:0] REG_PLAY_N     = 6'h0b;
  localparam logic [5:0] REG_PLAY_M     = 6'h0c;
  localparam logic [5:0] REG_PLAY_OSR_U = 6'h0d;
  localparam logic [5:0] REG_PLAY_OSR_L = 6'h0e;
  localparam logic [5:0] REG_REC_N      = 6'h12;
  localparam logic [5:0] REG_REC_M      = 6'h13;
  localparam logic [5:0] REG_REC_OSR    = 6'h14;
  localparam logic [5:0] REG_GP_SEL     = 6'h19;
  localparam logic [5:0] REG_GP_DIV     = 6'h1a;
  localparam logic [5:0] REG_SIF_CTRL   = 6'h1b;
  localparam logic [5:0] REG_SIF_CLK    = 6'h1d;
  localparam logic [5:0] REG_BCLK_DIV   = 6'h1e;
  localparam logic [5:0] REG_GP_ROUTE   = 6'h1f;
  localparam logic [5:0] REG_REC_STAT   = 6'h24;
  localparam logic [5:0] REG_PLAY_STAT  = 6'h25;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int DIV_EN_BIT    = 7;
  localparam int PLL_ON_BIT    = 7;
  localparam int BCLK_OUT_BIT  = 3;
  localparam int PLAY_L_STAT   = 7;
  localparam int PLAY_R_STAT   = 3;
  localparam int REC_STAT_BIT  = 6;
  localparam logic [7:0] RST_PLL_CTRL = 8'h11;
  localparam logic [7:0] RST_PLL_J    = 8'h04;
  localparam logic [7:0] RST_DIV      = 8'h01;
  localparam logic [7:0] RST_ZERO     = 8'h00;
  localparam logic [16:0] FRAC_SCALE  = 17'h02710;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ        = 200;
  localparam int LOCK_TIME_US   = 10000;
  localparam int LOCK_CYCLES    = LOCK_TIME_US * CLK_MHZ;

  // Divider stages of the tree
  typedef enum logic [2:0] {
    ST_PLAY_N   = 3'h0,
    ST_PLAY_M   = 3'h1,
    ST_PLAY_OSR = 3'h2,
    ST_REC_N    = 3'h3,
    ST_REC_M    = 3'h4,
    ST_REC_OSR  = 3'h5,
    ST_BCLK     = 3'h6,
    ST_GP       = 3'h7
  } stage_t;

  typedef struct packed {
    logic        en;
    logic [10:0] value;
  } div_cfg_t;

endpackage : clock_tree_pkg

// File: verilog/codec_clock_tree.sv
// Codec clock tree: root select, fractional synthesiser, divider chain
`timescale 1ns/1ps

module codec_clock_tree
  import clock_tree_pkg::*;
#(
  parameter int LOCK_WAIT = LOCK_CYCLES
) (
  input  wire logic        clk_sys_i,
  input  wire logic        resetn_i,
  input  wire logic [5:0]  address_i,
  input  wire logic        read_i,
  input  wire logic        write_i,
  input  wire logic [3:0]  byteenable_i,
  input  wire logic [31:0] writedata_i,
  output logic [31:0]      readdata_o,
  output logic             waitrequest_o,
  input  wire logic        master_clock_i,
  input  wire logic        bit_clock_i,
  input  wire logic        general_pin_one_i,
  input  wire logic        play_left_powered_i,
  input  wire logic        play_right_powered_i,
  input  wire logic        rec_powered_i,
  output logic             root_codec_clock_o,
  output logic             playback_block_clock_o,
  output logic             playback_modulator_clock_o,
  output logic             playback_sample_clock_o,
  output logic             record_block_clock_o,
  output logic             record_modulator_clock_o,
  output logic             record_sample_clock_o,
  output logic             bit_clock_o,
  output logic             bit_clock_oe_o,
  output logic             general_pin_one_o,
  output logic             general_pin_one_oe_o,
  output logic             serial_data_gp_o,
  output logic             serial_data_gp_oe_o,
  output logic             synth_locked_o
);
  import clock_tree_pkg::*;

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  logic [7:0]  cfg [0:63];
  logic [13:0] frac_active;
  logic [7:0]  stat_rec;
  logic [7:0]  stat_play;
  logic [7:0]  rd_byte;

  wire bus_req    = read_i | write_i;
  wire bus_accept = bus_req & ~waitrequest_o;
  wire wr_hit     = write_i & ~waitrequest_o & byteenable_i[0];
  wire is_status  = (address_i == REG_REC_STAT) |
                    (address_i == REG_PLAY_STAT);
  wire is_rw      = (address_i == REG_ROOT_SEL) |
                    (address_i == REG_PLL_CTRL) |
                    (address_i == REG_PLL_J) |
                    (address_i == REG_FRAC_UP) |
                    (address_i == REG_FRAC_LO) |
                    (address_i == REG_PLAY_N) |
                    (address_i == REG_PLAY_M) |
                    (address_i == REG_PLAY_OSR_U) |
                    (address_i == REG_PLAY_OSR_L) |
                    (address_i == REG_REC_N) |
                    (address_i == REG_REC_M) |
                    (address_i == REG_REC_OSR) |
                    (address_i == REG_GP_SEL) |
                    (address_i == REG_GP_DIV) |
                    (address_i == REG_SIF_CTRL) |
                    (address_i == REG_SIF_CLK) |
                    (address_i == REG_BCLK_DIV) |
                    (address_i == REG_GP_ROUTE);

  assign stat_rec  = {1'b0, rec_powered_i, 6'h00};
  assign stat_play = {play_left_powered_i, 3'h0,
                      play_right_powered_i, 3'h0};
  assign rd_byte   = (address_i == REG_REC_STAT)  ? stat_rec  :
                     (address_i == REG_PLAY_STAT) ? stat_play :
                     is_rw ? cfg[address_i] : 8'h00;

  function automatic logic [7:0] reset_val(input int idx);
    case (idx)
      REG_PLL_CTRL: reset_val = RST_PLL_CTRL;
      REG_PLL_J:    reset_val = RST_PLL_J;
      REG_PLAY_N, REG_PLAY_M, REG_REC_N, REG_REC_M, REG_GP_DIV,
      REG_BCLK_DIV: reset_val = RST_DIV;
      default:      reset_val = RST_ZERO;
    endcase
  endfunction : reset_val

  // One wait state: request seen, then answered the next edge
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
      waitrequest_o <= 1'b1;
    else
      waitrequest_o <= ~(bus_req & waitrequest_o);
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
      readdata_o <= 32'h0000_0000;
    else if (read_i & waitrequest_o)
      readdata_o <= {24'h00_0000, rd_byte};
  end

  for (genvar r = 0; r < 64; r++) begin : g_reg
    always_ff @(posedge clk_sys_i)
    begin
      if (!resetn_i)
        cfg[r] <= reset_val(r);
      else if (wr_hit & is_rw & ~is_status & (address_i == r))
        cfg[r] <= writedata_i[7:0];
    end
  end

  // Fraction takes effect only with the lower half write
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
      frac_active <= 14'h0000;
    else if (wr_hit & (address_i == REG_FRAC_LO))
      frac_active <= {cfg[REG_FRAC_UP][5:0], writedata_i[7:0]};
  end

  // ---------------------------------------------------------------
  // Pin sampling and edge ticks
  // ---------------------------------------------------------------
  logic [2:0] pin_s1;
  logic [2:0] pin_s2;
  logic [2:0] pin_s3;
  wire  [2:0] pin_tick = pin_s2 ^ pin_s3;

  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      pin_s1 <= 3'h0;
      pin_s2 <= 3'h0;
      pin_s3 <= 3'h0;
    end
    else
    begin
      pin_s1 <= {general_pin_one_i, bit_clock_i, master_clock_i};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // ---------------------------------------------------------------
  // Fractional synthesiser, modelled as an edge-rate accumulator
  // ---------------------------------------------------------------
  wire        pll_on  = cfg[REG_PLL_CTRL][PLL_ON_BIT];
  wire [3:0]  p_code  = {1'b0, cfg[REG_PLL_CTRL][6:4]};
  wire [4:0]  p_val   = (p_code == 4'h0) ? 5'h08 : {1'b0, p_code};
  wire [4:0]  r_val   = (cfg[REG_PLL_CTRL][3:0] == 4'h0) ? 5'h10 :
                        {1'b0, cfg[REG_PLL_CTRL][3:0]};
  wire [5:0]  j_val   = cfg[REG_PLL_J][5:0];
  wire [1:0]  syn_sel = cfg[REG_GP_ROUTE][3:2];
  logic [25:0] syn_acc;
  logic [31:0] lock_cnt;
  // Operands widened first so that J times scale cannot wrap
  wire [19:0] jd_val  = 20'(j_val) * 20'(FRAC_SCALE) +
                        20'(frac_active);
  wire [24:0] syn_inc = 25'(jd_val) * 25'(r_val);
  wire [16:0] syn_thr = 17'(p_val) * FRAC_SCALE;
  wire        syn_ref = pin_tick[syn_sel == 2'h3 ? 2'h0 : syn_sel];
  wire [25:0] acc_sum = syn_acc + (syn_ref ? {1'b0, syn_inc} : 26'h0);
  wire        acc_hit = acc_sum >= {9'h000, syn_thr};
  wire        syn_tick = pll_on & synth_locked_o & acc_hit;

  // Output rate is capped at one edge per system cycle
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i | ~pll_on)
      syn_acc <= 26'h0;
    else
      syn_acc <= acc_hit ? acc_sum - {9'h000, syn_thr} : acc_sum;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i | ~pll_on)
    begin
      lock_cnt       <= 32'h0;
      synth_locked_o <= 1'b0;
    end
    else if (lock_cnt < 32'(LOCK_WAIT))
      lock_cnt <= lock_cnt + 32'h1;
    else
      synth_locked_o <= 1'b1;
  end

  // ---------------------------------------------------------------
  // Root select and divider chain
  // ---------------------------------------------------------------
  logic [7:0]  src_tick;
  logic [7:0]  div_tick;
  div_cfg_t    cfg_div [0:7];
  wire [1:0]   root_sel  = cfg[REG_ROOT_SEL][1:0];
  wire         root_tick = (root_sel == 2'h3) ? syn_tick :
                           pin_tick[root_sel];
  wire play_busy = play_left_powered_i | play_right_powered_i;
  wire pm_en = cfg[REG_PLAY_M][DIV_EN_BIT] | play_busy;
  wire pn_en = cfg[REG_PLAY_N][DIV_EN_BIT] | pm_en;
  wire rm_en = cfg[REG_REC_M][DIV_EN_BIT] | rec_powered_i;
  wire rn_en = cfg[REG_REC_N][DIV_EN_BIT] | rm_en;
  wire rec_borrow = ~rn_en & ~rm_en;
  wire rec_blk = rec_borrow ? div_tick[ST_PLAY_N] : div_tick[ST_REC_N];
  wire rec_mod = rec_borrow ? div_tick[ST_PLAY_M] : div_tick[ST_REC_M];
  wire [1:0] bsel = cfg[REG_SIF_CLK][1:0];
  wire [2:0] gsel = cfg[REG_GP_SEL][2:0];
  wire [7:0] gp_pool = {rec_mod, rec_blk, div_tick[ST_PLAY_M],
                        div_tick[ST_PLAY_N], syn_tick, pin_tick};
  wire bclk_drive = cfg[REG_SIF_CTRL][BCLK_OUT_BIT];
  wire [1:0] gp_route = cfg[REG_GP_ROUTE][1:0];

  function automatic logic [10:0] div7(input logic [7:0] r);
    div7 = (r[6:0] == 7'h00) ? 11'h080 : {4'h0, r[6:0]};
  endfunction : div7

  wire [9:0] posr = {cfg[REG_PLAY_OSR_U][1:0], cfg[REG_PLAY_OSR_L]};

  assign src_tick[ST_PLAY_N]   = root_tick;
  assign src_tick[ST_PLAY_M]   = div_tick[ST_PLAY_N];
  assign src_tick[ST_PLAY_OSR] = div_tick[ST_PLAY_M];
  assign src_tick[ST_REC_N]    = root_tick;
  assign src_tick[ST_REC_M]    = div_tick[ST_REC_N];
  assign src_tick[ST_REC_OSR]  = rec_mod;
  assign src_tick[ST_BCLK]     = (bsel == 2'h0) ? div_tick[ST_PLAY_N] :
                                 (bsel == 2'h1) ? div_tick[ST_PLAY_M] :
                                 (bsel == 2'h2) ? rec_blk : rec_mod;
  assign src_tick[ST_GP]       = gp_pool[gsel];

  assign cfg_div[ST_PLAY_N]   = '{pn_en, div7(cfg[REG_PLAY_N])};
  assign cfg_div[ST_PLAY_M]   = '{pm_en, div7(cfg[REG_PLAY_M])};
  assign cfg_div[ST_PLAY_OSR] = '{pm_en,
                                  (posr == 10'h000) ? 11'h400 : {1'b0, posr}};
  assign cfg_div[ST_REC_N]    = '{rn_en, div7(cfg[REG_REC_N])};
  assign cfg_div[ST_REC_M]    = '{rm_en, div7(cfg[REG_REC_M])};
  assign cfg_div[ST_REC_OSR]  = '{rm_en | rec_borrow & pm_en,
                                  (cfg[REG_REC_OSR] == 8'h00) ? 11'h100 :
                                  {3'h0, cfg[REG_REC_OSR]}};
  assign cfg_div[ST_BCLK]     = '{bclk_drive,
                                  div7(cfg[REG_BCLK_DIV])};
  assign cfg_div[ST_GP]       = '{|gp_route, div7(cfg[REG_GP_DIV])};

  // Each stage counts source edges; the value is loaded only while off
  for (genvar s = 0; s < 8; s++) begin : g_div
    logic [10:0] held;
    logic [10:0] cnt;
    assign div_tick[s] = cfg_div[s].en & src_tick[s] &
                         (cnt == held - 11'h1);
    always_ff @(posedge clk_sys_i)
    begin
      if (!resetn_i)
      begin
        held <= 11'h001;
        cnt  <= 11'h000;
      end
      else if (!cfg_div[s].en)
      begin
        held <= cfg_div[s].value;
        cnt  <= 11'h000;
      end
      else if (src_tick[s])
        cnt <= div_tick[s] ? 11'h000 : cnt + 11'h1;
    end
  end

  // ---------------------------------------------------------------
  // Clock outputs: one level change per tick
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      root_codec_clock_o         <= 1'b0;
      playback_block_clock_o     <= 1'b0;
      playback_modulator_clock_o <= 1'b0;
      playback_sample_clock_o    <= 1'b0;
      record_block_clock_o       <= 1'b0;
      record_modulator_clock_o   <= 1'b0;
      record_sample_clock_o      <= 1'b0;
      bit_clock_o                <= 1'b0;
      general_pin_one_o          <= 1'b0;
      serial_data_gp_o           <= 1'b0;
    end
    else
    begin
      root_codec_clock_o         <= root_codec_clock_o ^ root_tick;
      playback_block_clock_o     <= playback_block_clock_o ^
                                    div_tick[ST_PLAY_N];
      playback_modulator_clock_o <= playback_modulator_clock_o ^
                                    div_tick[ST_PLAY_M];
      playback_sample_clock_o    <= playback_sample_clock_o ^
                                    div_tick[ST_PLAY_OSR];
      record_block_clock_o       <= record_block_clock_o ^ rec_blk;
      record_modulator_clock_o   <= record_modulator_clock_o ^ rec_mod;
      record_sample_clock_o      <= record_sample_clock_o ^
                                    div_tick[ST_REC_OSR];
      bit_clock_o                <= bit_clock_o ^ div_tick[ST_BCLK];
      general_pin_one_o          <= general_pin_one_o ^
                                    (div_tick[ST_GP] & gp_route[0]);
      serial_data_gp_o           <= serial_data_gp_o ^
                                    (div_tick[ST_GP] & gp_route[1]);
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      bit_clock_oe_o       <= 1'b0;
      general_pin_one_oe_o <= 1'b0;
      serial_data_gp_oe_o  <= 1'b0;
    end
    else
    begin
      bit_clock_oe_o       <= bclk_drive;
      general_pin_one_oe_o <= gp_route[0];
      serial_data_gp_oe_o  <= gp_route[1];
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  a_pll_off_dark: assert property (!pll_on |-> !syn_tick)
    else $error("synth edge while powered off");
  a_lock_settle: assert property (
    $rose(pll_on) |-> !synth_locked_o [*8])
    else $error("synth locked too early");
  a_frac_apply: assert property (
    wr_hit && address_i == REG_FRAC_LO
    |=> frac_active[7:0] == $past(writedata_i[7:0]))
    else $error("fraction not applied on lower write");
  a_frac_hold: assert property (
    wr_hit && address_i == REG_FRAC_UP |=> $stable(frac_active))
    else $error("fraction moved on upper write");
  a_play_hold: assert property (play_busy |-> pm_en && pn_en)
    else $error("playback divider dropped while busy");
  a_rec_hold: assert property (rec_powered_i |-> rm_en && rn_en)
    else $error("record divider dropped while busy");
  a_rec_borrow: assert property (
    rec_borrow |-> rec_mod == div_tick[ST_PLAY_M])
    else $error("record clock not borrowed");
  a_bclk_oe: assert property ($rose(bclk_drive) |=> bit_clock_oe_o)
    else $error("bit clock pin not driven");
  // A stopped divider restarts from zero, so its first period is whole
  a_div_quiet: assert property (
    !cfg_div[ST_PLAY_M].en |=> g_div[1].cnt == 11'h000)
    else $error("disabled divider kept its count");
  a_bus_answer: assert property (bus_req && waitrequest_o |=> !waitrequest_o)
    else $error("bus answer late");

  c_synth_lock: cover property ($rose(synth_locked_o));
  c_play_sample: cover property (div_tick[ST_PLAY_OSR]);
  c_rec_borrowed: cover property (rec_borrow && rec_mod);
  c_bclk_edge: cover property (bit_clock_oe_o && div_tick[ST_BCLK]);

endmodule : codec_clock_tree
